// file: dv/sdst_term.sv
// terminal model: offers command headers and command data bytes
// assumes ready outputs settle before each falling clock edge
`timescale 1ns/1ps
`default_nettype none
module sdst_term (
    // clock
    input wire logic clk,
    // header
    output logic cmd_valid,
    output logic [7:0] cmd_p1,
    output logic [7:0] cmd_p2,
    input wire logic cmd_ready,
    // data bytes
    output logic cd_valid,
    output logic [7:0] cd_byte,
    output logic cd_last,
    input wire logic cd_ready
);
    initial
    begin
        cmd_valid = 1'b0;
        cmd_p1 = 8'h00;
        cmd_p2 = 8'h00;
        cd_valid = 1'b0;
        cd_byte = 8'h00;
        cd_last = 1'b0;
    end
    // ready is read in the low phase, where it equals its edge value
    task automatic wait_rdy(input bit d);
        logic r;
        do
        begin
            @(negedge clk);
            r = d ? cd_ready : cmd_ready;
            @(posedge clk);
        end
        while (r !== 1'b1);
    endtask : wait_rdy
    task automatic hdr(input logic [7:0] p1, input logic [7:0] p2);
        cmd_valid <= 1'b1;
        cmd_p1 <= p1;
        cmd_p2 <= p2;
        wait_rdy(1'b0);
        cmd_valid <= 1'b0;
        cmd_p1 <= ~p1;
        cmd_p2 <= ~p2;
    endtask : hdr
    task automatic dat(input logic [7:0] b [$]);
        foreach (b[i])
        begin
            cd_valid <= 1'b1;
            cd_byte <= b[i];
            cd_last <= (i == b.size() - 1);
            wait_rdy(1'b1);
        end
        // a released line shows the inverse, never a stale byte
        cd_valid <= 1'b0;
        cd_byte <= ~b[b.size() - 1];
        cd_last <= 1'b0;
    endtask : dat
endmodule : sdst_term
`default_nettype wire

// file: dv/testbench.sv
// bench: terminal model drives commands, application side lives here
// assumes one command in flight and status after every command
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sdst_pkg::*;
    logic clk, rst_n, cmd_valid, cmd_ready, cd_valid, cd_ready, cd_last;
    logic [7:0] cmd_p1, cmd_p2, cd_byte, rx_byte, tx_len, tx_byte;
    logic [7:0] rsp_byte, sw1, sw2, blocks_left;
    logic rx_valid, rx_ready, tx_req, tx_retx, tx_valid, tx_ready;
    logic rsp_valid, rsp_ready, sw_valid, proact, no_mem, stall, tk, full;
    logic [1:0] rx_sess, tx_sess;
    logic [3:0] pend, sess_active, sess_abort;
    logic [7:0] pay [$];
    logic [9:0] rxq [$];
    logic [7:0] rspq [$];
    logic [19:0] swq [$];
    int n_errors = 0;
    int checked = 0;
    int ti;
    sdst_core #(.DEPTH(FIFO_DEPTH)) DUT (.clk(clk), .rst_n(rst_n),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_p1(cmd_p1),
        .cmd_p2(cmd_p2), .cd_valid(cd_valid), .cd_ready(cd_ready),
        .cd_byte(cd_byte), .cd_last(cd_last), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_byte(rx_byte), .rx_sess(rx_sess),
        .tx_req(tx_req), .tx_sess(tx_sess), .tx_retx(tx_retx),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_len(tx_len),
        .tx_byte(tx_byte), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
        .rsp_byte(rsp_byte), .sw_valid(sw_valid), .sw1(sw1), .sw2(sw2),
        .app_pend(pend), .app_proactive(proact), .app_no_mem(no_mem),
        .sess_active(sess_active), .sess_abort(sess_abort),
        .blocks_left(blocks_left));
    sdst_term term (.clk(clk), .cmd_valid(cmd_valid), .cmd_p1(cmd_p1),
        .cmd_p2(cmd_p2), .cmd_ready(cmd_ready), .cd_valid(cd_valid),
        .cd_byte(cd_byte), .cd_last(cd_last), .cd_ready(cd_ready));
    task automatic cmp_d(input logic [9:0] g, input logic [9:0] e);
        checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, g, e);
        end
    endtask : cmp_d
    task automatic cmp_s(input logic [19:0] g, input logic [19:0] e);
        checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, g, e);
        end
    endtask : cmp_s
    function automatic logic [7:0] sw2f(input logic rs, input logic [1:0] s);
        logic [1:0] p;
        p = pend[s] ? s : pend[0] ? 2'd0 : pend[1] ? 2'd1 :
            pend[2] ? 2'd2 : pend[3] ? 2'd3 : s;
        return {3'b000, rs, proact, p, |pend};
    endfunction : sw2f
    task automatic settle;
        int k;
        k = 0;
        while ((rxq.size() + rspq.size() + swq.size()) > 0 && k < 3000)
        begin
            @(posedge clk);
            k++;
        end
        cmp_d(10'(k / 3000), 10'h0);
        @(posedge clk);
    endtask : settle
    task automatic data_cmd(input logic [1:0] s, input logic [7:0] tg,
        input logic [7:0] len, input bit lng, input logic [7:0] p2);
        logic [7:0] b [$];
        logic bad;
        bad = (tg !== TAG_SC) || (lng && len <= LEN_SHORT_MAX);
        b = {tg};
        if (lng) b.push_back(LEN_LONG);
        b.push_back(len);
        for (int i = 0; i < len; i++)
        begin
            b.push_back(8'($urandom));
            if (!bad) rxq.push_back({s, b[$]});
        end
        if (no_mem) swq.push_back({4'b1 << s, SW_NO_MEM});
        else swq.push_back({4'h0, SW1_ONGOING, sw2f(bad, s)});
        term.hdr({s, 6'h04}, p2);
        term.dat(b);
        cmp_d({2'b0, blocks_left}, {2'b0, p2});
        settle();
    endtask : data_cmd
    task automatic resp_cmd(input logic [1:0] s, input logic rt,
        input logic [7:0] len);
        pend <= rt ? 4'h0 : 4'b1 << s;
        pay = {};
        repeat (len) pay.push_back(8'($urandom));
        @(posedge clk);
        rspq = {TAG_SC};
        if (len > LEN_SHORT_MAX) rspq.push_back(LEN_LONG);
        rspq.push_back(len);
        foreach (pay[i]) rspq.push_back(pay[i]);
        swq.push_back({4'h0, SW1_ONGOING, sw2f(1'b0, s)});
        ti <= 0;
        tx_len <= len;
        tx_byte <= (len > 0) ? pay[0] : 8'h00;
        tx_valid <= 1'b1;
        term.hdr({s, 5'h00, rt}, 8'h00);
        repeat (4)
        begin
            @(negedge clk);
            if (tx_req === 1'b1) break;
        end
        cmp_d({tx_sess, 7'h00, tx_retx}, {s, 7'h00, rt});
        cmp_d({9'h0, tx_req}, 10'h1);
        settle();
        cmp_d({9'h0, sess_active[s]}, {9'h0, !rt});
        tx_valid <= 1'b0;
    endtask : resp_cmd
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude
    // ------------------------------------------------
    // application side: random stalls on both outputs
    // ------------------------------------------------
    always @(posedge clk)
    begin
        rx_ready <= !stall && 1'($urandom);
        rsp_ready <= 1'($urandom);
        if (tk)
        begin
            ti <= ti + 1;
            tx_byte <= (ti + 1 < pay.size()) ? pay[ti + 1] : 8'h00;
        end
    end
    always @(negedge clk)
    begin
        tk = tx_valid && tx_ready;
        if (rx_valid && rx_ready)
            cmp_d({rx_sess, rx_byte}, rxq.pop_front());
        if (rsp_valid && rsp_ready)
            cmp_d({2'b0, rsp_byte}, {2'b0, rspq.pop_front()});
        if (sw_valid)
            cmp_s({sess_abort, sw1, sw2}, swq.pop_front());
        if (cd_valid && !cd_ready) full = 1'b1;
    end
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial
    begin
        #(40 * 60000);
        n_errors++;
        conclude();
    end
    initial
    begin
        {rst_n, rx_ready, rsp_ready, tx_valid, proact, no_mem} = 6'h0;
        {tx_len, tx_byte, pend, ti, tk, full, stall} = 0;
        void'($urandom(32'h3030));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        cmp_s({sess_abort, sw1, sw2}, 20'h0);
        for (int s = 0; s < NUM_SESS; s++)
        begin
            pend <= 4'($urandom);
            proact <= 1'($urandom);
            @(posedge clk);
            data_cmd(2'(s), TAG_SC, 8'($urandom_range(40)), 1'b0,
                8'(NUM_SESS - 1 - s));
        end
        $display("test short data done");
        stall <= 1'b1;
        full = 1'b0;
        fork
            begin
                repeat (100) @(posedge clk);
                stall <= 1'b0;
            end
        join_none
        data_cmd(2'd1, TAG_SC, 8'd130, 1'b1, 8'd0);
        cmp_d({9'h0, full}, 10'h1);
        $display("test long data done");
        data_cmd(2'd2, 8'h81, 8'd3, 1'b0, 8'd1);
        data_cmd(2'd3, TAG_SC, 8'h7f, 1'b1, 8'd1);
        $display("test faults done");
        for (int s = 0; s < NUM_SESS; s++)
            resp_cmd(2'(s), 1'b0, 8'($urandom_range(12)));
        resp_cmd(2'd2, 1'b0, 8'd130);
        resp_cmd(2'd1, 1'b1, 8'd5);
        $display("test responses done");
        for (int s = 0; s < NUM_SESS; s++)
        begin
            swq.push_back({4'b1 << s, SW1_ONGOING, sw2f(1'b0, 2'(s))});
            // retransmit bit set on odd sessions must be ignored
            term.hdr({2'(s), 5'h03, 1'(s)}, 8'h00);
            settle();
            cmp_d({9'h0, sess_active[s]}, 10'h0);
        end
        $display("test aborts done");
        no_mem <= 1'b1;
        @(posedge clk);
        data_cmd(2'd0, TAG_SC, 8'd4, 1'b0, 8'd0);
        no_mem <= 1'b0;
        $display("test no memory done");
        conclude();
    end
endmodule : testbench
`default_nettype wire

// file: inc/sdst_pkg.sv
// shared constants of the session transfer command block
// assumes a byte-wide command/response transport around it
package sdst_pkg;

    // ------------------------------------------------
    // first parameter byte (session control)
    // ------------------------------------------------
    localparam int P1_SESS_HI = 7;
    localparam int P1_SESS_LO = 6;
    localparam int P1_DATA = 2;
    localparam int P1_ABORT = 1;
    localparam int P1_RETX = 0;

    // ------------------------------------------------
    // second status byte of the ongoing answer
    // ------------------------------------------------
    localparam int SW2_RESEND = 4;
    localparam int SW2_PROACT = 3;
    localparam int SW2_SESS_HI = 2;
    localparam int SW2_SESS_LO = 1;
    localparam int SW2_MORE = 0;

    // ------------------------------------------------
    // status codes and tlv coding
    // ------------------------------------------------
    localparam logic [7:0] SW1_ONGOING = 8'h92;
    localparam logic [15:0] SW_NO_MEM = 16'h6a84;
    localparam logic [7:0] TAG_SC = 8'h80;
    localparam logic [7:0] LEN_LONG = 8'h81;
    localparam logic [7:0] LEN_SHORT_MAX = 8'h7f;

    // ------------------------------------------------
    // sizes and reset values
    // ------------------------------------------------
    localparam int NUM_SESS = 4;
    localparam int FIFO_DEPTH = 32;
    localparam logic [7:0] BYTE_RST = 8'h00;

    typedef enum logic [3:0] {
        ST_IDLE, ST_TAG, ST_LEN1, ST_LEN2, ST_VAL, ST_DRAIN,
        ST_RWAIT, ST_RL1, ST_RL2, ST_RPAY, ST_SW
    } sdst_state_e;

endpackage : sdst_pkg

// file: src/sdst_core.sv
// card-side session transfer command interpreter
// assumes the transport hands over parameter bytes and data bytes
// on the same clock; the application drains and sources payload
//
// Overview of operation
// - session number in p1 bits b8 b7
// - p1 b3 set means command carries data
// - p1 b2 clear continues, set aborts session
// - p1 b1 asks card to repeat response
// - p2 counts blocks terminal still sends
// - tlv tag one to three, length one-two
// - length below 128 short, else 81 prefix
// - only tag 80 defined, others reserved
// - normal answer is 92 with flag byte
// - sw2 b5 asks next or resend block
// - sw2 b4 flags pending proactive message
// - sw2 b3 b2 give pending block session
// - sw2 b1 set means more data pending
// - status 6a84 aborts the session
// - response data starts only on a command with neither data nor abort bit
// - response tlv uses session tag and format
// - data bit selects data or response form
// - four sessions interleave by session number
`timescale 1ns/1ps
`default_nettype none
module sdst_core #(
    parameter int DEPTH = sdst_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // command header
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [7:0] cmd_p1,
    input wire logic [7:0] cmd_p2,
    // command data bytes
    input wire logic cd_valid,
    output logic cd_ready,
    input wire logic [7:0] cd_byte,
    input wire logic cd_last,
    // received value bytes toward the application
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [7:0] rx_byte,
    output logic [1:0] rx_sess,
    // response payload from the application
    output logic tx_req,
    output logic [1:0] tx_sess,
    output logic tx_retx,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [7:0] tx_len,
    input wire logic [7:0] tx_byte,
    // response bytes toward the transport
    output logic rsp_valid,
    input wire logic rsp_ready,
    output logic [7:0] rsp_byte,
    // status words
    output logic sw_valid,
    output logic [7:0] sw1,
    output logic [7:0] sw2,
    // application state
    input wire logic [sdst_pkg::NUM_SESS-1:0] app_pend,
    input wire logic app_proactive,
    input wire logic app_no_mem,
    // session state
    output logic [sdst_pkg::NUM_SESS-1:0] sess_active,
    output logic [sdst_pkg::NUM_SESS-1:0] sess_abort,
    output logic [7:0] blocks_left
);
    import sdst_pkg::*;

    // ------------------------------------------------
    // state
    // ------------------------------------------------
    sdst_state_e st_q;
    logic [1:0] sess_q;
    logic data_q;
    logic abort_q;
    logic retx_q;
    logic err_q;
    logic [7:0] cnt_q;
    logic [7:0] p2_q;
    logic rsp_valid_q;
    logic [7:0] rsp_byte_q;
    logic sw_valid_q;
    logic [7:0] sw1_q;
    logic [7:0] sw2_q;
    logic [NUM_SESS-1:0] act_q;
    logic [NUM_SESS-1:0] abt_q;

    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    // first length byte: short form or the long-form prefix
    function automatic logic [7:0] len_first(input logic [7:0] n);
        return (n > LEN_SHORT_MAX) ? LEN_LONG : n;
    endfunction : len_first

    // pending session: own session first, else lowest pending one
    function automatic logic [1:0] pick(input logic [3:0] p,
                                        input logic [1:0] own);
        logic [1:0] r;
        r = own;
        if (!p[own])
        begin
            for (int i = NUM_SESS - 1; i >= 0; i--)
                if (p[i])
                    r = 2'(i);
        end
        return r;
    endfunction : pick

    // ------------------------------------------------
    // decode
    // ------------------------------------------------
    wire take_cmd = cmd_valid && cmd_ready;
    wire [1:0] p1_sess = cmd_p1[P1_SESS_HI:P1_SESS_LO];
    wire p1_data = cmd_p1[P1_DATA];
    wire p1_abort = cmd_p1[P1_ABORT];
    // retransmit has no meaning on a data command
    wire p1_retx = cmd_p1[P1_RETX] && !p1_data;
    wire out_free = !rsp_valid_q || rsp_ready;
    wire fifo_in_ready;
    wire parse_st = (st_q == ST_TAG) || (st_q == ST_LEN1) ||
                    (st_q == ST_LEN2) || (st_q == ST_DRAIN);
    wire take_cd = cd_valid && cd_ready;
    wire push = take_cd && (st_q == ST_VAL);
    wire tag_bad = (cd_byte != TAG_SC);
    wire len_short = (cd_byte <= LEN_SHORT_MAX);
    wire len_long = (cd_byte == LEN_LONG);
    wire take_tx = tx_valid && tx_ready;
    wire [1:0] pend_sess = pick(app_pend, sess_q);
    wire more = |app_pend;
    wire no_mem = data_q && !abort_q && app_no_mem;
    wire [7:0] sw2_ok = {3'b000, err_q, app_proactive,
                         pend_sess, more};
    wire done = !more && (p2_q == 8'h00);

    assign cmd_ready = (st_q == ST_IDLE);
    // back-pressure from the fifo stalls the data bytes
    assign cd_ready = parse_st || ((st_q == ST_VAL) && fifo_in_ready);
    assign tx_req = (st_q == ST_RWAIT);
    assign tx_ready = (st_q == ST_RPAY) && out_free;
    assign tx_sess = sess_q;
    assign tx_retx = retx_q;
    assign rsp_valid = rsp_valid_q;
    assign rsp_byte = rsp_byte_q;
    assign sw_valid = sw_valid_q;
    assign sw1 = sw1_q;
    assign sw2 = sw2_q;
    assign sess_active = act_q;
    assign sess_abort = abt_q;
    assign blocks_left = p2_q;

    // ------------------------------------------------
    // receive fifo
    // ------------------------------------------------
    sdst_fifo #(
        .W(10),
        .D(DEPTH)
    ) u_rx_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(push),
        .in_data({sess_q, cd_byte}),
        .in_ready(fifo_in_ready),
        .out_valid(rx_valid),
        .out_data({rx_sess, rx_byte}),
        .out_ready(rx_ready)
    );

    // ------------------------------------------------
    // command sequencer
    // ------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st_q <= ST_IDLE;
            sess_q <= 2'b00;
            data_q <= 1'b0;
            abort_q <= 1'b0;
            retx_q <= 1'b0;
            err_q <= 1'b0;
            cnt_q <= BYTE_RST;
            p2_q <= BYTE_RST;
        end
        else
        begin
            unique case (st_q)
                ST_IDLE:
                    if (take_cmd)
                    begin
                        sess_q <= p1_sess;
                        data_q <= p1_data;
                        abort_q <= p1_abort;
                        retx_q <= p1_retx;
                        err_q <= 1'b0;
                        p2_q <= cmd_p2;
                        if (p1_abort)
                            st_q <= ST_SW;
                        else if (p1_data)
                            st_q <= ST_TAG;
                        else if (app_pend[p1_sess] || p1_retx)
                            st_q <= ST_RWAIT;
                        else
                            st_q <= ST_SW;
                    end
                ST_TAG:
                    if (take_cd)
                    begin
                        err_q <= tag_bad;
                        if (cd_last)
                        begin
                            err_q <= 1'b1;
                            st_q <= ST_SW;
                        end
                        else
                            st_q <= tag_bad ? ST_DRAIN : ST_LEN1;
                    end
                ST_LEN1:
                    if (take_cd)
                    begin
                        cnt_q <= cd_byte;
                        if (len_short && cd_last)
                        begin
                            err_q <= (cd_byte != 8'h00);
                            st_q <= ST_SW;
                        end
                        else if (len_short && cd_byte != 8'h00)
                            st_q <= ST_VAL;
                        else if (len_long && !cd_last)
                            st_q <= ST_LEN2;
                        else
                        begin
                            err_q <= 1'b1;
                            st_q <= cd_last ? ST_SW : ST_DRAIN;
                        end
                    end
                ST_LEN2:
                    if (take_cd)
                    begin
                        cnt_q <= cd_byte;
                        // long form only for 128 and up
                        if (len_short || cd_last)
                        begin
                            err_q <= 1'b1;
                            st_q <= cd_last ? ST_SW : ST_DRAIN;
                        end
                        else
                            st_q <= ST_VAL;
                    end
                ST_VAL:
                    if (take_cd)
                    begin
                        cnt_q <= cnt_q - 8'h01;
                        if (cnt_q == 8'h01)
                        begin
                            err_q <= !cd_last;
                            st_q <= cd_last ? ST_SW : ST_DRAIN;
                        end
                        else if (cd_last)
                        begin
                            err_q <= 1'b1;
                            st_q <= ST_SW;
                        end
                    end
                ST_DRAIN:
                    if (take_cd && cd_last)
                        st_q <= ST_SW;
                ST_RWAIT:
                    if (tx_valid && out_free)
                    begin
                        cnt_q <= tx_len;
                        st_q <= ST_RL1;
                    end
                ST_RL1:
                    if (out_free)
                    begin
                        if (cnt_q > LEN_SHORT_MAX)
                            st_q <= ST_RL2;
                        else
                            st_q <= (cnt_q == 8'h00) ? ST_SW : ST_RPAY;
                    end
                ST_RL2:
                    if (out_free)
                        st_q <= ST_RPAY;
                ST_RPAY:
                    if (take_tx)
                    begin
                        cnt_q <= cnt_q - 8'h01;
                        if (cnt_q == 8'h01)
                            st_q <= ST_SW;
                    end
                ST_SW:
                    // status follows the last response byte out
                    if (!rsp_valid_q)
                        st_q <= ST_IDLE;
                default:
                    st_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------
    // response byte register
    // ------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rsp_valid_q <= 1'b0;
            rsp_byte_q <= BYTE_RST;
        end
        else if (out_free)
        begin
            rsp_valid_q <= 1'b0;
            if (st_q == ST_RWAIT && tx_valid)
            begin
                rsp_valid_q <= 1'b1;
                rsp_byte_q <= TAG_SC;
            end
            else if (st_q == ST_RL1)
            begin
                rsp_valid_q <= 1'b1;
                rsp_byte_q <= len_first(cnt_q);
            end
            else if (st_q == ST_RL2)
            begin
                rsp_valid_q <= 1'b1;
                rsp_byte_q <= cnt_q;
            end
            else if (take_tx)
            begin
                rsp_valid_q <= 1'b1;
                rsp_byte_q <= tx_byte;
            end
        end
    end

    // ------------------------------------------------
    // status words and session table
    // ------------------------------------------------
    wire sw_go = (st_q == ST_SW) && !rsp_valid_q;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sw_valid_q <= 1'b0;
            sw1_q <= BYTE_RST;
            sw2_q <= BYTE_RST;
            act_q <= '0;
            abt_q <= '0;
        end
        else
        begin
            sw_valid_q <= sw_go;
            abt_q <= '0;
            if (take_cmd && !p1_abort)
                act_q[p1_sess] <= 1'b1;
            if (sw_go)
            begin
                if (no_mem)
                    {sw1_q, sw2_q} <= SW_NO_MEM;
                else
                begin
                    sw1_q <= SW1_ONGOING;
                    sw2_q <= sw2_ok;
                end
                if (no_mem || abort_q)
                begin
                    act_q[sess_q] <= 1'b0;
                    abt_q[sess_q] <= 1'b1;
                end
                else if (done)
                    act_q[sess_q] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------
    // checks
    // ------------------------------------------------
    sequence hdr_take_s;
        cmd_valid && cmd_ready;
    endsequence

    sequence sw_out_s;
        ##1 (st_q == ST_SW) ##1 sw_valid;
    endsequence

    sess_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
        hdr_take_s |=> sess_q == $past(cmd_p1[7:6]))
        else $error("session number not taken from p1");

    data_form_a: assert property (@(posedge clk) disable iff (!rst_n)
        hdr_take_s and (cmd_p1[2] && !cmd_p1[1]) |=> st_q == ST_TAG)
        else $error("data command did not start tag parse");

    abort_path_a: assert property (@(posedge clk) disable iff (!rst_n)
        hdr_take_s and cmd_p1[1] |-> sw_out_s ##0 abt_q != '0)
        else $error("abort did not end the session");

    blocks_cnt_a: assert property (@(posedge clk) disable iff (!rst_n)
        hdr_take_s |=> blocks_left == $past(cmd_p2))
        else $error("remaining block count not latched");

    retx_ign_a: assert property (@(posedge clk) disable iff (!rst_n)
        hdr_take_s and cmd_p1[2] |=> !tx_retx)
        else $error("retransmit honoured on data command");

    tag_reject_a: assert property (@(posedge clk) disable iff (!rst_n)
        take_cd && st_q == ST_TAG && cd_byte != TAG_SC |=> err_q)
        else $error("reserved tag accepted");

    long_len_a: assert property (@(posedge clk) disable iff (!rst_n)
        st_q == ST_RL2 && out_free |-> rsp_byte == 8'h81 && cnt_q > 8'h7f
        ##1 rsp_valid && rsp_byte == $past(cnt_q))
        else $error("long length form wrong");

    sw_ongoing_a: assert property (@(posedge clk) disable iff (!rst_n)
        sw_valid |-> sw1 == 8'h92 || {sw1, sw2} == 16'h6a84)
        else $error("unexpected status word");

    sw2_rsvd_a: assert property (@(posedge clk) disable iff (!rst_n)
        sw_valid && sw1 == 8'h92 |-> sw2[7:5] == 3'b000)
        else $error("reserved status bits set");

    proact_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        sw_valid && sw1 == 8'h92 |-> sw2[3] == $past(app_proactive))
        else $error("proactive flag not reported");

    nomem_abt_a: assert property (@(posedge clk) disable iff (!rst_n)
        sw_valid && {sw1, sw2} == 16'h6a84 |-> abt_q != '0 ##1 !sw_valid)
        else $error("no-memory status did not abort");
endmodule : sdst_core
`default_nettype wire

// file: src/sdst_fifo.sv
// flip-flop fifo with valid/ready on both sides
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module sdst_fifo #(
    parameter int W = 10,
    parameter int D = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // fill side
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    // drain side
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (cnt_q != (AW+1)'(D));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];

    // wrap by depth so depths that are not a power of two work too
    function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
        return (p == AW'(D - 1)) ? '0 : p + 1'b1;
    endfunction : nxt

    always_ff @(posedge clk)
    begin
        if (push)
            mem_q[wr_q] <= in_data;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wr_q <= nxt(wr_q);
            if (pop)
                rd_q <= nxt(rd_q);
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : sdst_fifo
`default_nettype wire
